// file: src/sssf_cfg.svh
`ifndef SSSF_CFG_SVH
`define SSSF_CFG_SVH

// Word and frame geometry
`define SSSF_PAYLOAD_W 18
`define SSSF_FRAME_W 20
`define SSSF_POS_W 5
`define SSSF_BIT_LAST 5'h13
`define SSSF_HALF_FRAME 5'h0A
`define SSSF_POS_ZERO 5'h00

// Framing bit values
`define SSSF_START_BIT 1'b1
`define SSSF_STOP_BIT 1'b0

// Sync burst: nine ones then nine zeros, sent for 1024 frames
`define SSSF_SYNC_WORD 18'h001FF
`define SSSF_SYNC_FRAMES 11'h400
`define SSSF_SYNC_CNT_W 11
`define SSSF_SYNC_MIN 3'h6

// Lock acquisition and loss
`define SSSF_LOCK_HITS 3'h4
`define SSSF_LOCK_MISSES 3'h4
`define SSSF_HOLDOFF 4'h9

// APB register byte offsets
`define SSSF_REG_CTRL 8'h00
`define SSSF_REG_STATUS 8'h04
`define SSSF_REG_INT_STAT 8'h08
`define SSSF_REG_INT_MASK 8'h0C
`define SSSF_REG_RX_WORD 8'h10
`define SSSF_REG_TX_WORD 8'h14

// Control fields
`define SSSF_CTRL_LOOP 0
`define SSSF_CTRL_EMPH 1
`define SSSF_CTRL_SYNC 2
`define SSSF_CTRL_W 3
`define SSSF_CTRL_RST 3'h0

// Interrupt fields
`define SSSF_IRQ_LOCK_GAIN 0
`define SSSF_IRQ_LOCK_LOSS 1
`define SSSF_IRQ_SYNC_DONE 2
`define SSSF_IRQ_W 3
`define SSSF_IRQ_RST 3'h0

`endif

// file: src/sssf_pkg.sv
`include "sssf_cfg.svh"

package sssf_pkg;
   // Parallel payload word
   typedef logic [`SSSF_PAYLOAD_W-1:0] sssf_word_t;
   // Framed serial word
   typedef logic [`SSSF_FRAME_W-1:0] sssf_frame_t;
   // Bit position inside a frame
   typedef logic [`SSSF_POS_W-1:0] sssf_pos_t;
   // Interrupt status and mask layout
   typedef logic [`SSSF_IRQ_W-1:0] sssf_irq_t;
   // Receive alignment states
   typedef enum logic [1:0] {
      SSSF_HUNT,
      SSSF_CONFIRM,
      SSSF_LOCKED,
      SSSF_HOLDOFF
   } sssf_lock_state_t;
endpackage : sssf_pkg

// file: src/sssf_tx_if.sv
interface sssf_tx_if;
   import sssf_pkg::*;
   sssf_word_t word; // Held payload to frame
   logic emph_en; // Preemphasis select
   logic sync_go; // Start a sync burst
   logic bit_out; // Serial bit
   logic emph_out; // Larger swing flag for bit_out
   logic frame_load; // Pulse when a frame is loaded
   logic sync_busy; // Sync burst running
   logic sync_done; // Pulse at end of sync burst
   modport top (output word, output emph_en, output sync_go,
      input bit_out, input emph_out, input frame_load,
      input sync_busy, input sync_done);
   modport ser (input word, input emph_en, input sync_go,
      output bit_out, output emph_out, output frame_load,
      output sync_busy, output sync_done);
endinterface : sssf_tx_if

// file: src/sssf_serializer.sv
`include "sssf_cfg.svh"

module sssf_serializer (
   input wire logic sys_clk_in,
   input wire logic reset_in,
   sssf_tx_if.ser tx
);
   import sssf_pkg::*;

   sssf_pos_t bit_cnt; // Bit slot within frame
   sssf_frame_t shreg; // Frame shift register
   logic bit_clk; // Internal bit clock, toggles each slot
   logic [`SSSF_SYNC_CNT_W-1:0] sync_cnt; // Sync frames left
   sssf_word_t payload; // Payload chosen for next frame
   sssf_frame_t next_frame; // Frame being built
   logic load; // Frame load slot
   logic next_bit; // Bit that will be on the line next

   assign load = (bit_cnt == `SSSF_BIT_LAST);
   assign payload = tx.sync_busy ? `SSSF_SYNC_WORD : tx.word;
   // Stop on top, start at bit zero so it leaves first
   assign next_frame = {`SSSF_STOP_BIT, payload, `SSSF_START_BIT};
   assign next_bit = load ? next_frame[0] : shreg[1];
   assign tx.bit_out = shreg[0];
   assign tx.frame_load = load;

   // Bit slot counter; fixed load slot keeps latency constant
   always_ff @(posedge sys_clk_in) begin
      if (reset_in || load) begin
         bit_cnt <= `SSSF_POS_ZERO;
      end else begin
         bit_cnt <= bit_cnt + 5'h01;
      end
   end

   // Both edges of bit_clk each carry one bit
   always_ff @(posedge sys_clk_in) begin
      if (reset_in) begin
         bit_clk <= 1'b0;
      end else begin
         bit_clk <= ~bit_clk;
      end
   end

   // Shift right so payload bit zero follows the start bit
   always_ff @(posedge sys_clk_in) begin
      if (reset_in) begin
         shreg <= '0;
      end else if (load) begin
         shreg <= next_frame;
      end else begin
         shreg <= {1'b0, shreg[`SSSF_FRAME_W-1:1]};
      end
   end

   // Flag first bit of every run when preemphasis selected
   always_ff @(posedge sys_clk_in) begin
      if (reset_in) begin
         tx.emph_out <= 1'b0;
      end else begin
         tx.emph_out <= tx.emph_en && (next_bit != shreg[0]);
      end
   end

   // Sync burst length in frames, counted at load slots
   always_ff @(posedge sys_clk_in) begin
      if (reset_in) begin
         sync_cnt <= '0;
         tx.sync_busy <= 1'b0;
         tx.sync_done <= 1'b0;
      end else begin
         tx.sync_done <= 1'b0;
         if (tx.sync_go && !tx.sync_busy) begin
            sync_cnt <= `SSSF_SYNC_FRAMES;
            tx.sync_busy <= 1'b1;
         end else if (tx.sync_busy && load) begin
            sync_cnt <= sync_cnt - 11'h001;
            if (sync_cnt == 11'h001) begin
               tx.sync_busy <= 1'b0;
               tx.sync_done <= 1'b1;
            end
         end
      end
   end
endmodule : sssf_serializer

// file: src/sssf_framing.sv
// Local design decisions: the APB slave port and the placing of the registers.
`include "sssf_cfg.svh"

// Notes on behaviour
// - Capture transmit word each reference clock rise
// - Frame adds start one and stop zero
// - Shift on both bit clock edges
// - Payload bit zero sent first
// - Flag first bit of each run
// - Constant load to first bit delay
// - Retime received stream before deserializing
// - Find start/stop boundary, output payload
// - Word valid at recovered word clock rise
// - Loopback feeds own stream to receiver
// - Reset holds word clock low, outputs floated
// - Lock after four hits, drop after four misses
// - Lock inactive nine cycles, outputs floated
// - Long sync request sends 1024 sync frames
// - Loopback floats the serial output
module sssf_framing (
   input wire logic sys_clk_in,
   input wire logic reset_in,
   // Link side pins
   input wire logic ref_word_clock_in,
   input wire sssf_pkg::sssf_word_t tx_word_in,
   input wire logic serial_in_in,
   input wire logic loopback_select_in,
   input wire logic preemphasis_select_in,
   input wire logic sync_request_in,
   output logic serial_out_pos_out,
   output logic serial_out_neg_out,
   output logic serial_out_oe_out,
   output logic emphasis_out,
   output sssf_pkg::sssf_word_t rx_word_out,
   output logic rx_word_oe_out,
   output logic rx_word_clock_out,
   output logic rx_word_clock_oe_out,
   output logic link_locked_n_out,
   // APB slave
   input wire logic psel_in,
   input wire logic penable_in,
   input wire logic pwrite_in,
   input wire logic [7:0] paddr_in,
   input wire logic [31:0] pwdata_in,
   output logic [31:0] prdata_out,
   output logic pready_out,
   output logic pslverr_out,
   output logic irq_out
);
   import sssf_pkg::*;

   // Address decode used by the error path only; reads decode by case
   function automatic logic reg_mapped(input logic [7:0] addr);
      reg_mapped = (addr == `SSSF_REG_CTRL) ||
         (addr == `SSSF_REG_STATUS) ||
         (addr == `SSSF_REG_INT_STAT) ||
         (addr == `SSSF_REG_INT_MASK) ||
         (addr == `SSSF_REG_RX_WORD) ||
         (addr == `SSSF_REG_TX_WORD);
   endfunction : reg_mapped

   sssf_tx_if tx (); // Link to the serializer

   // Pin synchronisers, first stage read only by second
   logic ref_s1, ref_s2, ref_q; // Reference clock stages
   sssf_word_t txw_s1, txw_s2; // Transmit word stages
   logic ser_s1, ser_s2; // Serial input stages
   logic loop_s1, loop_s2; // Loopback select stages
   logic emph_s1, emph_s2; // Preemphasis select stages
   logic sync_s1, sync_s2; // Sync request stages

   // Control and status
   logic [`SSSF_CTRL_W-1:0] ctrl; // Software control bits
   sssf_irq_t int_stat; // Sticky event bits
   sssf_irq_t int_mask; // Interrupt enables
   sssf_irq_t irq_event; // One-cycle event pulses
   logic loopback; // Effective loopback
   logic sync_req; // Effective sync request
   logic [2:0] sync_hold; // Cycles sync request held high
   logic sync_fired; // Burst already started for this request

   // Transmit side
   sssf_word_t tx_hold; // Word captured at reference rise
   logic ref_rise; // Reference clock rising edge

   // Receive side
   logic rx_bit; // Retimed bit entering the window
   sssf_frame_t win; // Last twenty received bits
   sssf_pos_t pos; // Free running bit position
   sssf_pos_t phase; // Position of the found boundary
   sssf_pos_t clk_rise_pos; // Position of word clock rise
   logic boundary_ok; // Start and stop seen in window
   logic at_phase; // Window lines up with the boundary
   sssf_lock_state_t state; // Alignment state
   sssf_lock_state_t next_state; // Alignment next state
   logic [2:0] hits; // Consecutive boundary hits
   logic [2:0] misses; // Consecutive boundary misses
   logic [3:0] holdoff; // Lock-inactive hold counter
   logic locked; // Alignment locked

   // APB
   logic apb_write; // Write access phase
   logic apb_setup; // Setup phase

   // Two flip-flops on every foreign input
   always_ff @(posedge sys_clk_in) begin
      if (reset_in) begin
         ref_s1 <= 1'b0;
         ref_s2 <= 1'b0;
         ref_q <= 1'b0;
         ser_s1 <= 1'b0;
         ser_s2 <= 1'b0;
         loop_s1 <= 1'b0;
         loop_s2 <= 1'b0;
         emph_s1 <= 1'b0;
         emph_s2 <= 1'b0;
         sync_s1 <= 1'b0;
         sync_s2 <= 1'b0;
         txw_s1 <= '0;
         txw_s2 <= '0;
      end else begin
         ref_s1 <= ref_word_clock_in;
         ref_s2 <= ref_s1;
         ref_q <= ref_s2;
         ser_s1 <= serial_in_in;
         ser_s2 <= ser_s1;
         loop_s1 <= loopback_select_in;
         loop_s2 <= loop_s1;
         emph_s1 <= preemphasis_select_in;
         emph_s2 <= emph_s1;
         sync_s1 <= sync_request_in;
         sync_s2 <= sync_s1;
         txw_s1 <= tx_word_in;
         txw_s2 <= txw_s1;
      end
   end

   // Word and clock pass the same two stages, so they stay aligned
   assign ref_rise = ref_s2 && !ref_q;
   assign loopback = loop_s2 || ctrl[`SSSF_CTRL_LOOP];
   assign sync_req = sync_s2 || ctrl[`SSSF_CTRL_SYNC];

   // One word per reference clock rise, relying on host setup
   always_ff @(posedge sys_clk_in) begin
      if (reset_in) begin
         tx_hold <= '0;
      end else if (ref_rise) begin
         tx_hold <= txw_s2;
      end
   end

   // Sync request must outlast six cycles; one burst per request
   always_ff @(posedge sys_clk_in) begin
      if (reset_in || !sync_req) begin
         sync_hold <= 3'h0;
         sync_fired <= 1'b0;
      end else if (sync_hold != `SSSF_SYNC_MIN) begin
         sync_hold <= sync_hold + 3'h1;
      end else begin
         sync_fired <= 1'b1;
      end
   end

   assign tx.word = tx_hold;
   assign tx.emph_en = emph_s2 || ctrl[`SSSF_CTRL_EMPH];
   assign tx.sync_go = sync_req && (sync_hold == `SSSF_SYNC_MIN) &&
      !sync_fired;

   // Framing, shifting, emphasis and sync bursts
   sssf_serializer u_ser (
      .sys_clk_in (sys_clk_in),
      .reset_in (reset_in),
      .tx (tx.ser)
   );

   // Serial pins float in loopback and during reset
   always_ff @(posedge sys_clk_in) begin
      if (reset_in) begin
         serial_out_pos_out <= 1'b0;
         serial_out_neg_out <= 1'b1;
         serial_out_oe_out <= 1'b0;
         emphasis_out <= 1'b0;
      end else begin
         serial_out_pos_out <= tx.bit_out;
         serial_out_neg_out <= ~tx.bit_out;
         serial_out_oe_out <= !loopback;
         emphasis_out <= tx.emph_out;
      end
   end

   // Loopback taps the stream ahead of the pin stage
   assign rx_bit = loopback ? tx.bit_out : ser_s2;

   // New bits enter at the top; start ends at bit zero
   always_ff @(posedge sys_clk_in) begin
      if (reset_in) begin
         win <= '0;
      end else begin
         win <= {rx_bit, win[`SSSF_FRAME_W-1:1]};
      end
   end

   // Bit position wraps every frame
   always_ff @(posedge sys_clk_in) begin
      if (reset_in || pos == `SSSF_BIT_LAST) begin
         pos <= `SSSF_POS_ZERO;
      end else begin
         pos <= pos + 5'h01;
      end
   end

   assign boundary_ok = (win[0] == `SSSF_START_BIT) &&
      (win[`SSSF_FRAME_W-1] == `SSSF_STOP_BIT);
   assign at_phase = (pos == phase);
   assign locked = (state == SSSF_LOCKED);
   assign clk_rise_pos = (phase >= `SSSF_HALF_FRAME) ?
      phase - `SSSF_HALF_FRAME : phase + `SSSF_HALF_FRAME;

   // Alignment state decision
   always_comb begin
      next_state = state;
      unique case (state)
         SSSF_HUNT: begin
            if (boundary_ok) begin
               next_state = SSSF_CONFIRM;
            end
         end
         SSSF_CONFIRM: begin
            if (at_phase && !boundary_ok) begin
               next_state = SSSF_HUNT;
            end else if (at_phase &&
               (hits + 3'h1) == `SSSF_LOCK_HITS) begin
               next_state = SSSF_LOCKED;
            end
         end
         SSSF_LOCKED: begin
            if (at_phase && !boundary_ok &&
               (misses + 3'h1) == `SSSF_LOCK_MISSES) begin
               next_state = SSSF_HOLDOFF;
            end
         end
         SSSF_HOLDOFF: begin
            if ((holdoff + 4'h1) == `SSSF_HOLDOFF) begin
               next_state = SSSF_HUNT;
            end
         end
      endcase
   end

   // State register
   always_ff @(posedge sys_clk_in) begin
      if (reset_in) begin
         state <= SSSF_HUNT;
      end else begin
         state <= next_state;
      end
   end

   // Boundary phase and hit counting
   always_ff @(posedge sys_clk_in) begin
      if (reset_in) begin
         phase <= `SSSF_POS_ZERO;
         hits <= 3'h0;
      end else if (state == SSSF_HUNT && boundary_ok) begin
         phase <= pos; // First sighting counts as one
         hits <= 3'h1;
      end else if (state == SSSF_CONFIRM && at_phase && boundary_ok) begin
         hits <= hits + 3'h1;
      end
   end

   // Misses count only while locked; any hit clears them
   always_ff @(posedge sys_clk_in) begin
      if (reset_in || !locked) begin
         misses <= 3'h0;
      end else if (at_phase) begin
         misses <= boundary_ok ? 3'h0 : misses + 3'h1;
      end
   end

   // Nine cycles of forced lock-inactive after loss
   always_ff @(posedge sys_clk_in) begin
      if (reset_in || state != SSSF_HOLDOFF) begin
         holdoff <= 4'h0;
      end else begin
         holdoff <= holdoff + 4'h1;
      end
   end

   // Taken from lock entry on, so the first clock rise shows a word
   always_ff @(posedge sys_clk_in) begin
      if (reset_in) begin
         rx_word_out <= '0;
      end else if (next_state == SSSF_LOCKED && at_phase && boundary_ok) begin
         rx_word_out <= win[`SSSF_FRAME_W-2:1];
      end
   end

   // Word clock falls at update and rises half a frame later
   always_ff @(posedge sys_clk_in) begin
      if (reset_in || !locked) begin
         rx_word_clock_out <= 1'b0;
      end else if (at_phase) begin
         rx_word_clock_out <= 1'b0;
      end else if (pos == clk_rise_pos) begin
         rx_word_clock_out <= 1'b1;
      end
   end

   // Receive outputs drive only while locked; lock pin active low
   always_ff @(posedge sys_clk_in) begin
      if (reset_in) begin
         rx_word_oe_out <= 1'b0;
         rx_word_clock_oe_out <= 1'b0;
         link_locked_n_out <= 1'b1;
      end else begin
         rx_word_oe_out <= (next_state == SSSF_LOCKED);
         rx_word_clock_oe_out <= (next_state == SSSF_LOCKED);
         link_locked_n_out <= (next_state != SSSF_LOCKED);
      end
   end

   // Events that feed the sticky status bits
   assign irq_event[`SSSF_IRQ_LOCK_GAIN] = !locked &&
      (next_state == SSSF_LOCKED);
   assign irq_event[`SSSF_IRQ_LOCK_LOSS] = locked &&
      (next_state != SSSF_LOCKED);
   assign irq_event[`SSSF_IRQ_SYNC_DONE] = tx.sync_done;

   // Zero wait state slave
   assign apb_setup = psel_in && !penable_in;
   assign apb_write = psel_in && penable_in && pwrite_in;
   assign pready_out = 1'b1;
   assign pslverr_out = psel_in && penable_in && !reg_mapped(paddr_in);

   // Control register, written only at mapped offset
   always_ff @(posedge sys_clk_in) begin
      if (reset_in) begin
         ctrl <= `SSSF_CTRL_RST;
      end else if (apb_write && paddr_in == `SSSF_REG_CTRL) begin
         ctrl <= pwdata_in[`SSSF_CTRL_W-1:0];
      end
   end

   // Interrupt mask register
   always_ff @(posedge sys_clk_in) begin
      if (reset_in) begin
         int_mask <= `SSSF_IRQ_RST;
      end else if (apb_write && paddr_in == `SSSF_REG_INT_MASK) begin
         int_mask <= pwdata_in[`SSSF_IRQ_W-1:0];
      end
   end

   // Sticky bits, write one clears, a same-cycle event wins
   for (genvar i = 0; i < `SSSF_IRQ_W; i++) begin : g_irq
      always_ff @(posedge sys_clk_in) begin
         if (reset_in) begin
            int_stat[i] <= 1'b0;
         end else if (irq_event[i]) begin
            int_stat[i] <= 1'b1;
         end else if (apb_write && paddr_in == `SSSF_REG_INT_STAT &&
            pwdata_in[i]) begin
            int_stat[i] <= 1'b0;
         end
      end
   end

   // Level interrupt from any enabled sticky bit
   always_ff @(posedge sys_clk_in) begin
      if (reset_in) begin
         irq_out <= 1'b0;
      end else begin
         irq_out <= |(int_stat & int_mask);
      end
   end

   // Read data captured in setup so it is a flop in access phase
   always_ff @(posedge sys_clk_in) begin
      if (reset_in) begin
         prdata_out <= 32'h00000000;
      end else if (apb_setup) begin
         prdata_out <= 32'h00000000;
         unique case (paddr_in)
            `SSSF_REG_CTRL: begin
               prdata_out[`SSSF_CTRL_W-1:0] <= ctrl;
            end
            `SSSF_REG_STATUS: begin
               prdata_out[0] <= locked;
               prdata_out[1] <= tx.sync_busy;
               prdata_out[2] <= loopback;
               prdata_out[5:4] <= state;
            end
            `SSSF_REG_INT_STAT: begin
               prdata_out[`SSSF_IRQ_W-1:0] <= int_stat;
            end
            `SSSF_REG_INT_MASK: begin
               prdata_out[`SSSF_IRQ_W-1:0] <= int_mask;
            end
            `SSSF_REG_RX_WORD: begin
               prdata_out[`SSSF_PAYLOAD_W-1:0] <= rx_word_out;
            end
            `SSSF_REG_TX_WORD: begin
               prdata_out[`SSSF_PAYLOAD_W-1:0] <= tx_hold;
            end
            default: begin
               prdata_out <= 32'h00000000;
            end
         endcase
      end
   end
endmodule : sssf_framing

// file: verification/sssf_framing_checker.sv
module sssf_framing_checker (
   input wire logic sys_clk_in,
   input wire logic reset_in,
   input wire logic loopback_select_in,
   input wire logic preemphasis_select_in,
   input wire logic serial_out_pos_out,
   input wire logic serial_out_oe_out,
   input wire logic emphasis_out,
   input wire logic [17:0] rx_word_out,
   input wire logic rx_word_oe_out,
   input wire logic rx_word_clock_out,
   input wire logic link_locked_n_out,
   input wire logic psel_in,
   input wire logic penable_in,
   input wire logic [7:0] paddr_in,
   input wire logic pslverr_out
);
   // One domain, so clock and reset are given once
   default clocking cb @(posedge sys_clk_in); endclocking
   default disable iff (reset_in);
   // Reset values still show at the first edge after release
   a_reset_hold: assert property ($fell(reset_in) |-> !rx_word_clock_out
      && !rx_word_oe_out && !serial_out_oe_out)
      else $error("outputs not held in reset");
   a_loop_float: assert property (loopback_select_in[*4]
      |-> !serial_out_oe_out)
      else $error("serial output driven in loopback");
   a_oe_lock: assert property (rx_word_oe_out == !link_locked_n_out)
      else $error("rx drive differs from lock");
   a_clk_gated: assert property (!rx_word_oe_out
      |-> !rx_word_clock_out)
      else $error("word clock runs unlocked");
   a_lock_hold: assert property ($rose(link_locked_n_out)
      |=> link_locked_n_out[*8])
      else $error("lock back too soon");
   a_emph_run: assert property (emphasis_out
      |-> serial_out_pos_out != $past(serial_out_pos_out))
      else $error("emphasis inside a run");
   a_emph_on: assert property (preemphasis_select_in[*5] ##0
      (serial_out_pos_out != $past(serial_out_pos_out))
      |-> emphasis_out)
      else $error("run start not emphasised");
   // Word clock low eight cycles from its fall, high ten cycles after it
   a_clk_period: assert property ($fell(rx_word_clock_out) && rx_word_oe_out
      |-> !rx_word_clock_out[*8] ##3
      (rx_word_clock_out || !rx_word_oe_out))
      else $error("word clock period wrong");
   a_word_stable: assert property ($rose(rx_word_clock_out)
      |-> $stable(rx_word_out))
      else $error("word moves at clock rise");
   a_apb_err: assert property (psel_in && penable_in && paddr_in > 8'h14
      |-> pslverr_out)
      else $error("no error on unmapped access");
   c_lock: cover property ($fell(link_locked_n_out));
   c_loss: cover property ($rose(link_locked_n_out));
   c_emph: cover property (emphasis_out);
   c_loop: cover property (loopback_select_in && !link_locked_n_out);
endmodule : sssf_framing_checker

bind sssf_framing sssf_framing_checker i_sssf_framing_checker (
   .sys_clk_in, .reset_in, .loopback_select_in, .preemphasis_select_in,
   .serial_out_pos_out, .serial_out_oe_out, .emphasis_out, .rx_word_out,
   .rx_word_oe_out, .rx_word_clock_out, .link_locked_n_out, .psel_in,
   .penable_in, .paddr_in, .pslverr_out);

// file: verification/sssf_link_partner.sv
// Remote serializer sending a Johnson count, one bit per cycle
module sssf_link_partner (
   input wire logic sys_clk_in,
   input wire logic reset_in,
   input wire logic corrupt_in,
   output logic serial_out
);
   import sssf_pkg::*;
   logic [4:0] slot; // Bit slot within the frame
   sssf_word_t count; // Johnson count, so no false boundary lasts
   sssf_frame_t frame; // Stop, payload, start
   assign frame = {1'b0, count, 1'b1};
   // Corrupt sends all ones: no stop-to-start edge anywhere
   always_ff @(posedge sys_clk_in) begin
      if (reset_in) begin
         slot <= 5'h00;
         count <= 18'h00000;
         serial_out <= 1'b0;
      end else begin
         serial_out <= corrupt_in ? 1'b1 : frame[slot];
         slot <= (slot == 5'h13) ? 5'h00 : slot + 5'h01;
         if (slot == 5'h13) count <= {count[16:0], ~count[17]};
      end
   end
endmodule : sssf_link_partner

// file: verification/tb_start_stop_serdes_framing.sv
module tb_start_stop_serdes_framing;
   timeunit 1ns;
   timeprecision 1ns;
   import sssf_pkg::*;
   logic sys_clk_in = 1'b0; // 20 MHz system clock
   logic reset_in = 1'b1;
   logic ref_word_clock_in = 1'b0; // 400 ns link clock
   sssf_word_t tx_word_in = 18'h00000; // Held static across rises
   logic serial_in_in, loopback_select_in = 1'b0;
   logic preemphasis_select_in = 1'b0, sync_request_in = 1'b0;
   logic psel_in = 1'b0, penable_in = 1'b0, pwrite_in = 1'b0;
   logic [7:0] paddr_in = 8'h00;
   logic [31:0] pwdata_in = 32'h0, prdata_out;
   logic serial_out_pos_out, serial_out_neg_out, serial_out_oe_out;
   logic emphasis_out, rx_word_oe_out, rx_word_clock_out;
   logic rx_word_clock_oe_out, link_locked_n_out;
   logic pready_out, pslverr_out, irq_out;
   sssf_word_t rx_word_out;
   logic corrupt = 1'b0; // Partner breaks framing
   sssf_frame_t sr; // Last twenty serial bits, oldest low
   int fail_count = 0;
   int checks = 0;
   always #25 sys_clk_in = ~sys_clk_in;
   // Offset keeps link clock off system edges
   initial begin
      #37;
      forever #200 ref_word_clock_in = ~ref_word_clock_in;
   end
   always @(posedge sys_clk_in) sr <= {serial_out_pos_out, sr[19:1]};
   sssf_framing i_sssf_framing (.sys_clk_in, .reset_in,
      .ref_word_clock_in, .tx_word_in, .serial_in_in, .loopback_select_in,
      .preemphasis_select_in, .sync_request_in, .serial_out_pos_out,
      .serial_out_neg_out, .serial_out_oe_out, .emphasis_out, .rx_word_out,
      .rx_word_oe_out, .rx_word_clock_out, .rx_word_clock_oe_out,
      .link_locked_n_out, .psel_in, .penable_in, .pwrite_in, .paddr_in,
      .pwdata_in, .prdata_out, .pready_out, .pslverr_out, .irq_out);
   sssf_link_partner i_sssf_link_partner (.sys_clk_in, .reset_in,
      .corrupt_in(corrupt), .serial_out(serial_in_in));
   task automatic report_and_stop;
      if (fail_count == 0 && checks > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask : report_and_stop
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp) begin
         fail_count++;
         $display("mismatch at %0t: got %h want %h", $time, got, exp);
      end
   endtask : chk
   // Setup, access, release after pready
   task automatic apb(input logic wr, input logic [7:0] a,
      input logic [31:0] d, output logic [31:0] q);
      @(posedge sys_clk_in);
      psel_in <= 1'b1;
      pwrite_in <= wr;
      paddr_in <= a;
      pwdata_in <= d;
      @(posedge sys_clk_in);
      penable_in <= 1'b1;
      do @(posedge sys_clk_in); while (pready_out !== 1'b1);
      q = prdata_out;
      psel_in <= 1'b0;
      penable_in <= 1'b0;
   endtask : apb
   // Cycles until lock pin shows v, at most n
   task automatic wait_lock(input logic v, input int n, output int c);
      c = 0;
      while (link_locked_n_out !== v && c < n) begin
         @(posedge sys_clk_in);
         c++;
      end
   endtask : wait_lock
   // Look for one frame of w on the serial pin
   task automatic hunt(input sssf_word_t w);
      repeat (60) begin
         @(negedge sys_clk_in);
         if (sr === {1'b0, w, 1'b1}) break;
      end
      chk({12'h0, sr}, {12'h0, 1'b0, w, 1'b1});
   endtask : hunt
   task automatic t_reset;
      logic [31:0] q;
      @(negedge sys_clk_in);
      chk({rx_word_clock_out, rx_word_oe_out, serial_out_oe_out}, 0);
      repeat (20) @(posedge sys_clk_in);
      reset_in <= 1'b0;
      apb(1'b0, 8'h00, 0, q);
      chk(q, 0);
      apb(1'b0, 8'h0C, 0, q);
      chk(q, 0);
      apb(1'b0, 8'h20, 0, q);
      chk(q, 0);
   endtask : t_reset
   task automatic t_loopback;
      int c;
      loopback_select_in <= 1'b1;
      tx_word_in <= 18'h003FF;
      wait_lock(1'b0, 600, c);
      chk(link_locked_n_out, 0);
      chk(serial_out_oe_out, 0);
      @(posedge rx_word_clock_out);
      #1 chk(rx_word_out, 18'h003FF);
      @(posedge sys_clk_in);
      tx_word_in <= 18'h15A3C;
      repeat (60) @(posedge sys_clk_in);
      @(posedge rx_word_clock_out);
      #1 chk(rx_word_out, 18'h15A3C);
   endtask : t_loopback
   task automatic t_frame;
      @(posedge sys_clk_in);
      loopback_select_in <= 1'b0;
      preemphasis_select_in <= 1'b1;
      repeat (5) @(posedge sys_clk_in);
      chk(serial_out_oe_out, 1);
      chk(serial_out_neg_out, !serial_out_pos_out);
      hunt(18'h15A3C);
      repeat (20) @(negedge sys_clk_in);
      chk({12'h0, sr}, {13'h0, 18'h15A3C, 1'b1});
   endtask : t_frame
   task automatic t_lock;
      int c;
      sssf_word_t w;
      wait_lock(1'b1, 300, c);
      wait_lock(1'b0, 1000, c);
      chk(link_locked_n_out, 0);
      @(posedge rx_word_clock_out);
      #1 w = rx_word_out;
      @(posedge rx_word_clock_out);
      #1 chk(rx_word_out, {w[16:0], ~w[17]});
      @(posedge sys_clk_in);
      corrupt <= 1'b1;
      wait_lock(1'b1, 300, c);
      chk(c >= 60 && c <= 125, 1);
      chk({rx_word_oe_out, rx_word_clock_oe_out}, 0);
      corrupt <= 1'b0;
      wait_lock(1'b0, 1000, c);
      chk(c >= 60 && c < 1000, 1);
   endtask : t_lock
   task automatic t_sync;
      logic [31:0] q;
      int c;
      apb(1'b0, 8'h08, 0, q);
      chk(q[1], 1);
      chk(irq_out, 0);
      apb(1'b1, 8'h08, 32'h3, q);
      apb(1'b1, 8'h0C, 32'h4, q);
      sync_request_in <= 1'b1;
      repeat (4) @(posedge sys_clk_in);
      sync_request_in <= 1'b0;
      apb(1'b0, 8'h04, 0, q);
      chk(q[1], 0);
      apb(1'b1, 8'h00, 32'h4, q);
      repeat (10) @(posedge sys_clk_in);
      apb(1'b0, 8'h04, 0, q);
      chk(q[1], 1);
      hunt(18'h001FF);
      c = 0;
      while (irq_out !== 1'b1 && c < 21000) begin
         @(posedge sys_clk_in);
         c++;
      end
      chk(c > 20300 && c < 20600, 1);
      apb(1'b0, 8'h08, 0, q);
      chk(q[2], 1);
      apb(1'b1, 8'h08, 32'h4, q);
      repeat (3) @(posedge sys_clk_in);
      chk(irq_out, 0);
   endtask : t_sync
   initial begin
      t_reset();
      t_loopback();
      t_frame();
      t_lock();
      t_sync();
      report_and_stop();
   end
   // Whole run is a little over the 20480-cycle sync burst
   initial begin
      #2000000;
      fail_count++;
      report_and_stop();
   end
endmodule : tb_start_stop_serdes_framing
